// [design/dcc_cal_engine.sv]
// module: calibration sequencer for one converter
module dcc_cal_engine (
  // clock and reset
  input logic clock,
  input logic resetn,
  // register bank side
  dcc_eng_if.eng eng_io
);
  typedef enum logic [1:0]
  {
    DCC_IDLE = 2'b01,
    DCC_BUSY = 2'b10
  } dcc_eng_state_t;

  typedef struct packed
  {
    dcc_eng_state_t state;
    logic [7:0] cnt;
    logic done;
    logic fail;
  } dcc_eng_t;

  localparam dcc_eng_t ENG_RST = '{state: DCC_IDLE, cnt: 8'h00, done: 1'b0, fail: 1'b0};

  dcc_eng_t s_q;
  dcc_eng_t s_d;

  always_comb
  begin
    s_d = s_q;
    eng_io.finish = 1'b0;
    if (!eng_io.run)
    begin
      s_d = ENG_RST;
    end
    else
    begin
      case (s_q.state)
        DCC_IDLE:
        begin
          if (eng_io.start)
          begin
            s_d.state = DCC_BUSY;
            s_d.cnt = eng_io.steps;
            s_d.done = 1'b0;
            s_d.fail = 1'b0;
          end
        end
        DCC_BUSY:
        begin
          if (eng_io.start)
          begin
            s_d.cnt = eng_io.steps;
          end
          else if (eng_io.tick && !eng_io.clk_off)
          begin
            if (s_q.cnt <= 8'h01)
            begin
              s_d.state = DCC_IDLE;
              s_d.done = 1'b1;
              s_d.fail = eng_io.fail_in;
              eng_io.finish = 1'b1;
            end
            else
            begin
              s_d.cnt = s_q.cnt - 8'h01;
            end
          end
        end
        default:
        begin
          s_d = ENG_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= ENG_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign eng_io.active = (s_q.state == DCC_BUSY);
  assign eng_io.done = s_q.done;
  assign eng_io.fail = s_q.fail;

  a_fail_needs_done: assert property (@(posedge clock) disable iff (!resetn)
    eng_io.fail |-> eng_io.done && !eng_io.active) else $error("fail flag without done");
endmodule : dcc_cal_engine

// [design/dcc_eng_if.sv]
// interface: control and status between the register bank and one calibration engine
interface dcc_eng_if;
  logic run;
  logic start;
  logic tick;
  logic clk_off;
  logic fail_in;
  logic [7:0] steps;
  logic active;
  logic done;
  logic fail;
  logic finish;
  modport eng (input run, start, tick, clk_off, fail_in, steps, output active, done, fail, finish);
  modport ctl (output run, start, tick, clk_off, fail_in, steps, input active, done, fail, finish);
endinterface : dcc_eng_if

// [design/dcc_pkg.sv]
// package: register map, field positions and reset values of the calibration register bank
package dcc_pkg;
  // register indexes; byte address is four times the index
  localparam logic [9:0] IDX_PAGE = 10'h008;
  localparam logic [9:0] IDX_CLK_DIV = 10'h050;
  localparam logic [9:0] IDX_CTRL = 10'h051;
  localparam logic [9:0] IDX_STAT = 10'h052;
  localparam logic [9:0] IDX_FSC = 10'h05A;
  localparam logic [9:0] IDX_TUNE = 10'h061;
  localparam logic [9:0] IDX_CLK_PWR = 10'h081;
  localparam logic [9:0] IDX_RING = 10'h083;
  localparam logic [9:0] IDX_INT_STAT = 10'h0F0;
  localparam logic [9:0] IDX_INT_MASK = 10'h0F1;
  // field positions
  localparam int CTRL_RUN_BIT = 7;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 2;
  localparam int STAT_FAIL_BIT = 1;
  localparam int STAT_DONE_BIT = 0;
  localparam int TUNE_A_BIT = 6;
  localparam int TUNE_B_BIT = 5;
  localparam int TUNE_C_BIT = 3;
  localparam int RING_HI_BIT = 7;
  localparam int INT_FAIL_LSB = 2;
  // reset values
  localparam logic [1:0] RST_PAGE = 2'h1;
  localparam logic RST_RUN = 1'h1;
  localparam logic [1:0] RST_MODE = 2'h1;
  localparam logic [7:0] RST_FSC = 8'h28;
  localparam logic [7:0] RST_CLK_DIV = 8'h28;
  localparam logic [2:0] RST_TUNE = 3'h6;
  localparam logic [1:0] RST_CLK_OFF = 2'h0;
  localparam logic RST_RING_HI = 1'h0;
  localparam logic [1:0] RST_RING_DIV = 2'h2;
  localparam logic [3:0] RST_INT = 4'h0;
  // ring divider base ratio and calibration length in ticks
  localparam logic [6:0] RING_BASE_DIV = 7'h08;
  localparam logic [7:0] CAL_BASE_STEPS = 8'h10;
endpackage : dcc_pkg

// [design/dcc_regs.sv]
// module: calibration control and status register bank on an Avalon-MM slave
//
// Added by the designer: the Avalon-MM register port.
module dcc_regs (
  // clock and reset
  input logic clock,
  input logic resetn,
  // avalon-mm slave
  input logic [11:0] address,
  input logic read,
  input logic write,
  input logic [31:0] writedata,
  input logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // converter side
  input logic [1:0] cal_fail_in,
  output logic [7:0] fsc_code_ch0,
  output logic [7:0] fsc_code_ch1,
  output logic [1:0] calib_mode_ch0,
  output logic [1:0] calib_mode_ch1,
  output logic calib_tune_a,
  output logic calib_tune_b,
  output logic calib_tune_c,
  output logic calib_clk_off_ch0,
  output logic calib_clk_off_ch1,
  output logic ring_osc_ctl_hi,
  output logic [1:0] ring_osc_divide,
  output logic [1:0] calib_active,
  // interrupt
  output logic irq
);
  typedef struct packed
  {
    logic ack;
    logic [31:0] rdata;
    logic [1:0] page;
    logic run;
    logic [1:0][1:0] mode;
    logic [1:0][7:0] fsc;
    logic [7:0] clk_div;
    logic [2:0] tune;
    logic [1:0] clk_off;
    logic ring_hi;
    logic [1:0] ring_div;
    logic [6:0] rcnt;
    logic tick;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
  } dcc_regs_t;

  localparam dcc_regs_t REGS_RST = '{
    ack: 1'b0,
    rdata: 32'h00000000,
    page: dcc_pkg::RST_PAGE,
    run: dcc_pkg::RST_RUN,
    mode: {dcc_pkg::RST_MODE, dcc_pkg::RST_MODE},
    fsc: {dcc_pkg::RST_FSC, dcc_pkg::RST_FSC},
    clk_div: dcc_pkg::RST_CLK_DIV,
    tune: dcc_pkg::RST_TUNE,
    clk_off: dcc_pkg::RST_CLK_OFF,
    ring_hi: dcc_pkg::RST_RING_HI,
    ring_div: dcc_pkg::RST_RING_DIV,
    rcnt: 7'h00,
    tick: 1'b0,
    int_stat: dcc_pkg::RST_INT,
    int_mask: dcc_pkg::RST_INT
  };

  dcc_regs_t s_q;
  dcc_regs_t s_d;

  logic [9:0] widx;
  logic aligned;
  logic wr;
  logic rd;
  logic ch;
  logic [6:0] rlim;
  logic [7:0] rv;
  logic [1:0] act;
  logic [1:0] dn;
  logic [1:0] fl;
  logic [1:0] fin;
  logic [1:0] start;
  logic [3:0] clr;

  dcc_eng_if eif[2] ();

  // engines, one per converter
  for (genvar i = 0; i < 2; i++)
  begin : g_eng
    assign eif[i].run = s_q.run;
    assign eif[i].start = start[i];
    assign eif[i].tick = s_q.tick;
    assign eif[i].clk_off = s_q.clk_off[i];
    assign eif[i].fail_in = cal_fail_in[i];
    assign eif[i].steps = dcc_pkg::CAL_BASE_STEPS + {4'h0, s_q.clk_div[3:0]};
    assign act[i] = eif[i].active;
    assign dn[i] = eif[i].done;
    assign fl[i] = eif[i].fail;
    assign fin[i] = eif[i].finish;
    dcc_cal_engine u_eng (
      .clock(clock),
      .resetn(resetn),
      .eng_io(eif[i])
    );
  end

  // bus decode
  assign widx = address[11:2];
  assign aligned = (address[1:0] == 2'h0);
  assign wr = write && s_q.ack && byteenable[0] && aligned;
  assign rd = read && !s_q.ack;
  assign ch = (s_q.page == 2'h2);
  assign rlim = dcc_pkg::RING_BASE_DIV << s_q.ring_div;
  assign clr = (wr && widx == dcc_pkg::IDX_INT_STAT) ? writedata[3:0] : 4'h0;

  // launch strobes for the paged converters
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      start[i] = wr && widx == dcc_pkg::IDX_CTRL && writedata[dcc_pkg::CTRL_START_BIT]
        && s_q.page[i];
    end
  end

  // read mux
  always_comb
  begin
    rv = 8'h00;
    if (aligned)
    begin
      case (widx)
        dcc_pkg::IDX_PAGE:
        begin
          rv = {6'h00, s_q.page};
        end
        dcc_pkg::IDX_CLK_DIV:
        begin
          rv = s_q.clk_div;
        end
        dcc_pkg::IDX_CTRL:
        begin
          rv[dcc_pkg::CTRL_RUN_BIT] = s_q.run;
          rv[dcc_pkg::CTRL_MODE_LSB +: 2] = s_q.mode[ch];
        end
        dcc_pkg::IDX_STAT:
        begin
          rv[dcc_pkg::STAT_ACTIVE_BIT] = act[ch];
          rv[dcc_pkg::STAT_FAIL_BIT] = fl[ch];
          rv[dcc_pkg::STAT_DONE_BIT] = dn[ch];
        end
        dcc_pkg::IDX_FSC:
        begin
          rv = s_q.fsc[ch];
        end
        dcc_pkg::IDX_TUNE:
        begin
          rv[dcc_pkg::TUNE_A_BIT] = s_q.tune[2];
          rv[dcc_pkg::TUNE_B_BIT] = s_q.tune[1];
          rv[dcc_pkg::TUNE_C_BIT] = s_q.tune[0];
        end
        dcc_pkg::IDX_CLK_PWR:
        begin
          rv = {6'h00, s_q.clk_off};
        end
        dcc_pkg::IDX_RING:
        begin
          rv[dcc_pkg::RING_HI_BIT] = s_q.ring_hi;
          rv[1:0] = s_q.ring_div;
        end
        dcc_pkg::IDX_INT_STAT:
        begin
          rv = {4'h0, s_q.int_stat};
        end
        dcc_pkg::IDX_INT_MASK:
        begin
          rv = {4'h0, s_q.int_mask};
        end
        default:
        begin
          rv = 8'h00;
        end
      endcase
    end
  end

  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.ack = (read || write) && !s_q.ack;
    if (rd)
    begin
      s_d.rdata = {24'h000000, rv};
    end
    // ring oscillator divider tick
    s_d.tick = (s_q.rcnt >= rlim - 7'h01);
    s_d.rcnt = s_d.tick ? 7'h00 : s_q.rcnt + 7'h01;
    if (wr)
    begin
      case (widx)
        dcc_pkg::IDX_PAGE:
        begin
          s_d.page = writedata[1:0];
        end
        dcc_pkg::IDX_CLK_DIV:
        begin
          s_d.clk_div = writedata[7:0];
        end
        dcc_pkg::IDX_CTRL:
        begin
          s_d.run = writedata[dcc_pkg::CTRL_RUN_BIT];
          for (int i = 0; i < 2; i++)
          begin
            if (s_q.page[i])
            begin
              s_d.mode[i] = writedata[dcc_pkg::CTRL_MODE_LSB +: 2];
            end
          end
        end
        dcc_pkg::IDX_FSC:
        begin
          for (int i = 0; i < 2; i++)
          begin
            if (s_q.page[i])
            begin
              s_d.fsc[i] = writedata[7:0];
            end
          end
        end
        dcc_pkg::IDX_TUNE:
        begin
          s_d.tune = {writedata[dcc_pkg::TUNE_A_BIT], writedata[dcc_pkg::TUNE_B_BIT],
            writedata[dcc_pkg::TUNE_C_BIT]};
        end
        dcc_pkg::IDX_CLK_PWR:
        begin
          s_d.clk_off = writedata[1:0];
        end
        dcc_pkg::IDX_RING:
        begin
          s_d.ring_hi = writedata[dcc_pkg::RING_HI_BIT];
          s_d.ring_div = writedata[1:0];
        end
        dcc_pkg::IDX_INT_MASK:
        begin
          s_d.int_mask = writedata[3:0];
        end
        default:
        begin
          s_d.run = s_q.run;
        end
      endcase
    end
    // sticky events, set wins over write-one-to-clear
    s_d.int_stat = (s_q.int_stat & ~clr) | {fin & cal_fail_in, fin};
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= REGS_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs
  assign readdata = s_q.rdata;
  assign waitrequest = (read || write) && !s_q.ack;
  assign fsc_code_ch0 = s_q.fsc[0];
  assign fsc_code_ch1 = s_q.fsc[1];
  assign calib_mode_ch0 = s_q.mode[0];
  assign calib_mode_ch1 = s_q.mode[1];
  assign calib_tune_a = s_q.tune[2];
  assign calib_tune_b = s_q.tune[1];
  assign calib_tune_c = s_q.tune[0];
  assign calib_clk_off_ch0 = s_q.clk_off[0];
  assign calib_clk_off_ch1 = s_q.clk_off[1];
  assign ring_osc_ctl_hi = s_q.ring_hi;
  assign ring_osc_divide = s_q.ring_div;
  assign calib_active = act;
  assign irq = |(s_q.int_stat & s_q.int_mask);

  // checks
  a_start_sets_active: assert property (@(posedge clock) disable iff (!resetn)
    start[0] && s_q.run |=> act[0] && !dn[0] && !fl[0]) else $error("start did not launch converter 0");

  a_run_low_resets: assert property (@(posedge clock) disable iff (!resetn)
    !s_q.run |=> act == 2'h0 && dn == 2'h0 && fl == 2'h0) else $error("engine not held in reset");

  a_active_holds: assert property (@(posedge clock) disable iff (!resetn)
    act[1] && s_q.run && !s_q.tick |=> act[1]) else $error("active dropped without tick");

  a_finish_flags: assert property (@(posedge clock) disable iff (!resetn)
    fin[0] |=> !act[0] && dn[0] && fl[0] == $past(cal_fail_in[0])) else $error("finish flags wrong");

  a_done_sticky: assert property (@(posedge clock) disable iff (!resetn)
    dn[1] && s_q.run && !start[1] |=> dn[1]) else $error("done flag lost");

  a_page_status: assert property (@(posedge clock) disable iff (!resetn)
    rd && aligned && widx == dcc_pkg::IDX_STAT && s_q.page == 2'h2
    |=> readdata[2:0] == {$past(act[1]), $past(fl[1]), $past(dn[1])}) else $error("paged status read wrong");

  a_fsc_write: assert property (@(posedge clock) disable iff (!resetn)
    wr && widx == dcc_pkg::IDX_FSC && s_q.page == 2'h2
    |=> fsc_code_ch1 == $past(writedata[7:0]) && fsc_code_ch0 == $past(fsc_code_ch0))
    else $error("paged full-scale write wrong");

  a_ring_tick_gap: assert property (@(posedge clock) disable iff (!resetn)
    s_q.tick |=> !s_q.tick [*7]) else $error("ring divider tick too early");

  a_ring_div_eight: assert property (@(posedge clock) disable iff (!resetn)
    s_q.tick ##1 (s_q.ring_div == 2'h0) [*8] |-> s_q.tick) else $error("divide by 8 tick missing");

  a_bus_one_wait: assert property (@(posedge clock) disable iff (!resetn)
    (read || write) && waitrequest |=> !waitrequest) else $error("waitrequest held too long");

  c_launch_ch0: cover property (@(posedge clock) disable iff (!resetn) start[0] && s_q.run);
  c_done_ch1: cover property (@(posedge clock) disable iff (!resetn) fin[1]);
  c_fail_ch1: cover property (@(posedge clock) disable iff (!resetn) fin[1] && cal_fail_in[1]);
  c_irq_rise: cover property (@(posedge clock) disable iff (!resetn) $rose(irq));
endmodule : dcc_regs

// [sim/test_dcc_regs.sv]
// testbench: self-checking bench for the calibration register bank
module test_dcc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [11:0] adr; logic [7:0] val;} dcc_row_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] address = 12'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] cal_fail_in = 2'h0;
  logic [7:0] fsc_code_ch0, fsc_code_ch1;
  logic [1:0] calib_mode_ch0, calib_mode_ch1, ring_osc_divide, calib_active;
  logic calib_tune_a, calib_tune_b, calib_tune_c, calib_clk_off_ch0, calib_clk_off_ch1, ring_osc_ctl_hi, irq;
  int miscompares = 0;
  int checked = 0;
  dcc_row_t rows [24];
  logic [7:0] rd;
  int w;
  dcc_regs dcc_regs_i (.clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .cal_fail_in(cal_fail_in), .fsc_code_ch0(fsc_code_ch0), .fsc_code_ch1(fsc_code_ch1),
    .calib_mode_ch0(calib_mode_ch0), .calib_mode_ch1(calib_mode_ch1), .calib_tune_a(calib_tune_a),
    .calib_tune_b(calib_tune_b), .calib_tune_c(calib_tune_c), .calib_clk_off_ch0(calib_clk_off_ch0),
    .calib_clk_off_ch1(calib_clk_off_ch1), .ring_osc_ctl_hi(ring_osc_ctl_hi),
    .ring_osc_divide(ring_osc_divide), .calib_active(calib_active), .irq(irq));
  always #10 clock = ~clock;
  function automatic logic [11:0] wa(input logic [9:0] i);
    return {i, 2'b00};
  endfunction : wa
  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : check_byte
  task automatic check_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit
  // one avalon transfer, held until waitrequest is low
  task automatic bus(input logic wr, input logic [11:0] adr, input logic [7:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    address <= adr;
    writedata <= {24'h000000, wd};
    byteenable <= be;
    read <= !wr;
    write <= wr;
    @(posedge clock);
    while (waitrequest !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        miscompares++;
        $display("CHECK FAILED at %0t: bus hang", $time);
        tally_and_finish();
      end
      @(posedge clock);
    end
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(negedge clock);
  endtask : bus
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    bus(1'b1, wa(i), d, 4'hF);
  endtask : wr
  task automatic rdc(input logic [9:0] i, input logic [7:0] exp);
    bus(1'b0, wa(i), 8'h00, 4'hF);
    check_byte(rd, exp);
  endtask : rdc
  // bounded wait until a converter is idle; no banked writes meanwhile
  task automatic wait_idle(input int ch, output int n);
    n = 0;
    while (calib_active[ch] === 1'b1)
    begin
      n++;
      if (n > 2000)
      begin
        miscompares++;
        $display("CHECK FAILED at %0t: calibration hang", $time);
        tally_and_finish();
      end
      @(negedge clock);
    end
  endtask : wait_idle
  // launch on a page, time the run, then check flags and interrupt
  task automatic cal_run(input logic [1:0] pg, input logic [7:0] msk, input logic [7:0] st, input logic [7:0] ist);
    int n;
    wr(dcc_pkg::IDX_PAGE, {6'h00, pg});
    wr(dcc_pkg::IDX_INT_MASK, msk);
    wr(dcc_pkg::IDX_CTRL, 8'h83);
    check_bit(calib_active[pg[1]], 1'b1);
    wait_idle(pg[1], n);
    check_bit(n >= 201 && n <= 208, 1'b1);
    rdc(dcc_pkg::IDX_STAT, st);
    check_bit(irq, 1'b1);
    rdc(dcc_pkg::IDX_INT_STAT, ist);
    wr(dcc_pkg::IDX_INT_STAT, 8'h0F);
    @(negedge clock);
    check_bit(irq, 1'b0);
  endtask : cal_run
  initial
  begin
    rows[0] = '{1'b0, wa(dcc_pkg::IDX_CTRL), 8'h82};
    rows[1] = '{1'b0, wa(dcc_pkg::IDX_STAT), 8'h00};
    rows[2] = '{1'b0, wa(dcc_pkg::IDX_FSC), 8'h28};
    rows[3] = '{1'b0, wa(dcc_pkg::IDX_TUNE), 8'h60};
    rows[4] = '{1'b0, wa(dcc_pkg::IDX_CLK_PWR), 8'h00};
    rows[5] = '{1'b0, wa(dcc_pkg::IDX_RING), 8'h02};
    rows[6] = '{1'b0, wa(dcc_pkg::IDX_PAGE), 8'h01};
    rows[7] = '{1'b0, wa(dcc_pkg::IDX_INT_STAT), 8'h00};
    rows[8] = '{1'b0, wa(dcc_pkg::IDX_INT_MASK), 8'h00};
    rows[9] = '{1'b1, wa(dcc_pkg::IDX_FSC), 8'h55};
    rows[10] = '{1'b0, wa(dcc_pkg::IDX_FSC), 8'h55};
    rows[11] = '{1'b1, wa(dcc_pkg::IDX_TUNE), 8'hFF};
    rows[12] = '{1'b0, wa(dcc_pkg::IDX_TUNE), 8'h68};
    rows[13] = '{1'b1, wa(dcc_pkg::IDX_CLK_PWR), 8'hFF};
    rows[14] = '{1'b0, wa(dcc_pkg::IDX_CLK_PWR), 8'h03};
    rows[15] = '{1'b1, wa(dcc_pkg::IDX_CLK_PWR), 8'h00};
    rows[16] = '{1'b1, wa(dcc_pkg::IDX_RING), 8'hFF};
    rows[17] = '{1'b0, wa(dcc_pkg::IDX_RING), 8'h83};
    rows[18] = '{1'b1, wa(dcc_pkg::IDX_RING), 8'h80};
    rows[19] = '{1'b1, wa(dcc_pkg::IDX_STAT), 8'hFF};
    rows[20] = '{1'b0, wa(dcc_pkg::IDX_STAT), 8'h00};
    rows[21] = '{1'b1, wa(dcc_pkg::IDX_CLK_DIV), 8'h0A};
    rows[22] = '{1'b1, 12'h145, 8'h00};
    rows[23] = '{1'b0, 12'h3E0, 8'h00};
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    foreach (rows[k])
    begin
      bus(rows[k].wr, rows[k].adr, rows[k].val, 4'hF);
      if (!rows[k].wr)
      begin
        check_byte(rd, rows[k].val);
      end
    end
    rdc(dcc_pkg::IDX_CTRL, 8'h82);
    rdc(dcc_pkg::IDX_CLK_DIV, 8'h0A);
    check_byte(fsc_code_ch0, 8'h55);
    check_bit(calib_tune_a & calib_tune_b & calib_tune_c, 1'b1);
    check_byte({ring_osc_ctl_hi, 5'h00, ring_osc_divide}, 8'h80);
    check_byte({calib_clk_off_ch1, calib_clk_off_ch0, calib_mode_ch0}, 8'h01);
    wr(dcc_pkg::IDX_PAGE, 8'h02);
    wr(dcc_pkg::IDX_FSC, 8'h33);
    rdc(dcc_pkg::IDX_FSC, 8'h33);
    check_byte(fsc_code_ch1, 8'h33);
    check_byte(fsc_code_ch0, 8'h55);
    wr(dcc_pkg::IDX_PAGE, 8'h03);
    wr(dcc_pkg::IDX_CTRL, 8'h84);
    check_byte({calib_mode_ch1, calib_mode_ch0}, 8'h0A);
    wr(dcc_pkg::IDX_CTRL, 8'h82);
    wr(dcc_pkg::IDX_RING, 8'h00);
    cal_run(2'h1, 8'h01, 8'h01, 8'h01);
    @(posedge clock);
    cal_fail_in <= 2'h2;
    cal_run(2'h2, 8'h08, 8'h03, 8'h0A);
    @(posedge clock);
    cal_fail_in <= 2'h0;
    // stalled clock keeps the run open until the clock returns, then run bit low clears the done flag
    wr(dcc_pkg::IDX_PAGE, 8'h01);
    wr(dcc_pkg::IDX_CLK_PWR, 8'h01);
    wr(dcc_pkg::IDX_CTRL, 8'h83);
    repeat (300) @(posedge clock);
    check_bit(calib_active[0], 1'b1);
    rdc(dcc_pkg::IDX_STAT, 8'h04);
    wr(dcc_pkg::IDX_CLK_PWR, 8'h00);
    wait_idle(0, w);
    rdc(dcc_pkg::IDX_STAT, 8'h01);
    wr(dcc_pkg::IDX_CTRL, 8'h02);
    @(negedge clock);
    check_bit(calib_active[0], 1'b0);
    rdc(dcc_pkg::IDX_STAT, 8'h00);
    wr(dcc_pkg::IDX_CTRL, 8'h82);
    bus(1'b1, wa(dcc_pkg::IDX_FSC), 8'h77, 4'hE);
    rdc(dcc_pkg::IDX_FSC, 8'h55);
    // second reset in mid-run
    wr(dcc_pkg::IDX_CTRL, 8'h83);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    check_byte({calib_active, calib_mode_ch0, 3'h0, irq}, 8'h10);
    rdc(dcc_pkg::IDX_FSC, 8'h28);
    rdc(dcc_pkg::IDX_CLK_DIV, 8'h28);
    rdc(dcc_pkg::IDX_CTRL, 8'h82);
    tally_and_finish();
  end
endmodule : test_dcc_regs
